// ### tcp_ctrl_regs.sv
// tcp_ctrl_regs: control page register bank of the imager, serial slave port included
// assumes: frame_start and nvm_* come from logic on mclk; scl, sda and straps are raw pins
`timescale 1ns/1ps

// Functional notes
// RULE1: shadowed frame registers take written values only at the next frame start
// RULE2: host never writes unmapped addresses; such writes are dropped here
// RULE3: reset restores every register to its factory value
// RULE4: reset values are the post-sequencer-load defaults
// RULE5: read-only family type and mask revision registers
// RULE6: read/write indirect address and data registers for the nonvolatile memory
// RULE7: strap register shows low strap in bit 5, high strap in bit 6
// RULE8: straps are scanned once after reset release, replacing the defaults
// RULE9: sample select bits 1:0 pick first modulator correlation sample 0..3
// RULE10: bits 3:2 pick second modulator correlation sample, dual modes only
// RULE11: bits 5:4 code 11 enables background suppression, 00 disables it and saturation
// RULE12: four frame sample select registers, defaults 30, 35, 3A, 3F
// RULE13: four frame illumination control registers, zero defaults
// RULE14: illumination bit 4 set holds illumination on during integration
// RULE15: illumination bit 5 set holds illumination off during integration
// RULE16: grayscale readout mode bit 0 selects single-ended or differential readout
// RULE17: grayscale illumination control register with same choices, default 26
// RULE18: host changes non-shadowed registers only outside frame acquisition
// RULE19: first data byte sets the register pointer, which steps after every byte
// RULE20: reserved bits read their default and ignore writes
module tcp_ctrl_regs
  import tcp_pkg::*;
#(
  parameter logic [7:0] FAMILY_TYPE_ID   = 8'hA5,  // arbitrary value
  parameter logic [7:0] MASK_REVISION_ID = 8'h01,  // arbitrary value
  parameter logic [4:0] DEV_ADDR_UPPER   = 5'h04
) (
  input  wire logic            mclk,
  input  wire logic            rst_n,
  input  wire logic            scl_i,
  input  wire logic            sda_i,
  output      logic            sda_o,
  output      logic            sda_oe,
  input  wire logic            strap_low_i,
  input  wire logic            strap_high_i,
  input  wire logic            frame_start,
  input  wire logic [7:0]      nvm_rdata,
  input  wire logic            nvm_rdata_valid,
  output      logic [7:0]      nvm_addr,
  output      logic [7:0]      nvm_wdata,
  output      logic            nvm_data_wr,
  output      logic [3:0][1:0] first_mod_sample,
  output      logic [3:0][1:0] second_mod_sample,
  output      logic [3:0]      bsup_en,
  output      logic [3:0]      sat_detect_en,
  output      logic [3:0]      illum_cont_on,
  output      logic [3:0]      illum_hold_off,
  output      logic            gray_diff_readout,
  output      logic            gray_illum_on,
  output      logic            gray_illum_off,
  output      logic            bus_address_strap_low,
  output      logic            bus_address_strap_high
);
  typedef struct packed {
    logic            strap_done;
    logic [1:0]      strap_cnt;
    logic            strap_low;
    logic            strap_high;
    logic [7:0]      ptr;
    logic [7:0]      rd_data;
    logic [7:0]      nvm_addr;
    logic [7:0]      nvm_data;
    logic            nvm_data_wr;
    logic [3:0][7:0] sel_wr;
    logic [3:0][7:0] illum_wr;
    logic [3:0][7:0] sel_act;
    logic [3:0][7:0] illum_act;
    logic [7:0]      gray_mode;
    logic [7:0]      gray_illum;
    logic [3:0][1:0] first_sample;
    logic [3:0][1:0] second_sample;
    logic [3:0]      bsup_en;
    logic [3:0]      sat_en;
    logic [3:0]      illum_on;
    logic [3:0]      illum_off;
    logic            gray_diff;
    logic            gray_on;
    logic            gray_off;
  } tcp_regs_type;

  // factory values; decoded outputs match the decoded reset registers
  localparam tcp_regs_type REGS_RESET = '{
    strap_done    : 1'b0,
    strap_cnt     : 2'd0,
    strap_low     : RST_STRAP[STRAP_LOW_BIT],
    strap_high    : RST_STRAP[STRAP_HIGH_BIT],
    ptr           : 8'h00,
    rd_data       : 8'h00,
    nvm_addr      : RST_NVM,
    nvm_data      : RST_NVM,
    nvm_data_wr   : 1'b0,
    sel_wr        : RST_FRAME_SEL,
    illum_wr      : {FRAMES{RST_FRAME_ILLUM}},
    sel_act       : RST_FRAME_SEL,
    illum_act     : {FRAMES{RST_FRAME_ILLUM}},
    gray_mode     : RST_GRAY_MODE,
    gray_illum    : RST_GRAY_ILLUM,
    first_sample  : {RST_FRAME_SEL[3][1:0], RST_FRAME_SEL[2][1:0],
                     RST_FRAME_SEL[1][1:0], RST_FRAME_SEL[0][1:0]},
    second_sample : {RST_FRAME_SEL[3][3:2], RST_FRAME_SEL[2][3:2],
                     RST_FRAME_SEL[1][3:2], RST_FRAME_SEL[0][3:2]},
    bsup_en       : 4'hF,
    sat_en        : 4'hF,
    illum_on      : 4'h0,
    illum_off     : 4'h0,
    gray_diff     : RST_GRAY_MODE[GRAY_DIFF_BIT],
    gray_on       : RST_GRAY_ILLUM[ILLUM_ON_BIT],
    gray_off      : RST_GRAY_ILLUM[ILLUM_OFF_BIT]
  };

  tcp_regs_type regs_reg;
  tcp_regs_type regs_next;
  logic         strap_low_s;
  logic         strap_high_s;
  logic         wr_valid;
  logic [7:0]   wr_data;
  logic         wr_first;
  logic         rd_next;

  // reserved bits keep their reset value
  function automatic logic [7:0] merge_bits(input logic [7:0] dflt,
                                            input logic [7:0] mask,
                                            input logic [7:0] data);
    return (dflt & ~mask) | (data & mask);  // [RULE20]
  endfunction : merge_bits

  // register readback at a byte address
  function automatic logic [7:0] read_mux(input tcp_regs_type s, input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      ADDR_FAMILY_TYPE: v = FAMILY_TYPE_ID;    // [RULE5]
      ADDR_MASK_REV:    v = MASK_REVISION_ID;  // [RULE5]
      ADDR_NVM_ADDR:    v = s.nvm_addr;        // [RULE6]
      ADDR_NVM_DATA:    v = s.nvm_data;        // [RULE6]
      ADDR_STRAP: begin
        v[STRAP_LOW_BIT]  = s.strap_low;       // [RULE7]
        v[STRAP_HIGH_BIT] = s.strap_high;      // [RULE7]
      end
      ADDR_GRAY_MODE:   v = s.gray_mode;
      ADDR_GRAY_ILLUM:  v = s.gray_illum;
      default: begin
        for (int f = 0; f < FRAMES; f++) begin
          if (addr == ADDR_FRAME_SEL[f]) begin
            v = s.sel_wr[f];
          end
          if (addr == ADDR_FRAME_ILLUM[f]) begin
            v = s.illum_wr[f];
          end
        end
      end
    endcase
    return v;
  endfunction : read_mux

  tcp_sync #(.WIDTH(2)) u_strap_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({strap_high_i, strap_low_i}),
    .sync_out ({strap_high_s, strap_low_s})
  );

  tcp_ser_slave u_ser (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .dev_addr ({DEV_ADDR_UPPER, regs_reg.strap_high, regs_reg.strap_low}),
    .rd_data  (regs_reg.rd_data),
    .sda_o    (sda_o),
    .sda_oe   (sda_oe),
    .wr_valid (wr_valid),
    .wr_data  (wr_data),
    .wr_first (wr_first),
    .rd_next  (rd_next)
  );

  always_comb begin
    regs_next             = regs_reg;
    regs_next.nvm_data_wr = 1'b0;

    // strap scan after the synchroniser has settled
    if (!regs_reg.strap_done) begin
      if (regs_reg.strap_cnt == STRAP_SETTLE) begin
        regs_next.strap_low  = strap_low_s;   // [RULE8]
        regs_next.strap_high = strap_high_s;  // [RULE8]
        regs_next.strap_done = 1'b1;
      end else begin
        regs_next.strap_cnt = regs_reg.strap_cnt + 2'd1;
      end
    end

    // host byte writes and pointer stepping
    if (wr_valid) begin
      if (wr_first) begin
        regs_next.ptr = wr_data;  // [RULE19]
      end else begin
        if (regs_reg.ptr == ADDR_NVM_ADDR) begin
          regs_next.nvm_addr = wr_data;  // [RULE6]
        end
        if (regs_reg.ptr == ADDR_NVM_DATA) begin
          regs_next.nvm_data    = wr_data;  // [RULE6]
          regs_next.nvm_data_wr = 1'b1;
        end
        if (regs_reg.ptr == ADDR_GRAY_MODE) begin
          regs_next.gray_mode = merge_bits(RST_GRAY_MODE, MASK_GRAY_MODE, wr_data);
        end
        if (regs_reg.ptr == ADDR_GRAY_ILLUM) begin
          regs_next.gray_illum = merge_bits(RST_GRAY_ILLUM, MASK_ILLUM, wr_data);  // [RULE17]
        end
        for (int f = 0; f < FRAMES; f++) begin
          if (regs_reg.ptr == ADDR_FRAME_SEL[f]) begin
            regs_next.sel_wr[f] = merge_bits(RST_FRAME_SEL[f], MASK_SEL, wr_data);  // [RULE12]
          end
          if (regs_reg.ptr == ADDR_FRAME_ILLUM[f]) begin
            regs_next.illum_wr[f] = merge_bits(RST_FRAME_ILLUM, MASK_ILLUM, wr_data);  // [RULE13]
          end
        end
        // unmapped addresses fall through with no effect [RULE2]
        regs_next.ptr = regs_reg.ptr + 8'h01;  // [RULE19]
      end
    end else if (rd_next) begin
      regs_next.ptr = regs_reg.ptr + 8'h01;  // [RULE19]
    end

    // memory read result lands after any host write in the same cycle
    if (nvm_rdata_valid) begin
      regs_next.nvm_data = nvm_rdata;
    end

    // shadow copies go live at frame start
    if (frame_start) begin
      regs_next.sel_act   = regs_reg.sel_wr;    // [RULE1]
      regs_next.illum_act = regs_reg.illum_wr;  // [RULE1]
    end

    // per-frame field decode of the live copies
    for (int f = 0; f < FRAMES; f++) begin
      regs_next.first_sample[f]  = regs_next.sel_act[f][SEL_FIRST_LSB +: 2];   // [RULE9]
      regs_next.second_sample[f] = regs_next.sel_act[f][SEL_SECOND_LSB +: 2];  // [RULE10]
      regs_next.bsup_en[f] = regs_next.sel_act[f][SEL_BSUP_LSB +: 2] == BSUP_ON;  // [RULE11]
      regs_next.sat_en[f]  = regs_next.sel_act[f][SEL_BSUP_LSB +: 2] != BSUP_OFF; // [RULE11]
      regs_next.illum_on[f]  = regs_next.illum_act[f][ILLUM_ON_BIT];   // [RULE14]
      regs_next.illum_off[f] = regs_next.illum_act[f][ILLUM_OFF_BIT];  // [RULE15]
    end

    // grayscale settings act at once
    regs_next.gray_diff = regs_next.gray_mode[GRAY_DIFF_BIT];   // [RULE16]
    regs_next.gray_on   = regs_next.gray_illum[ILLUM_ON_BIT];   // [RULE17]
    regs_next.gray_off  = regs_next.gray_illum[ILLUM_OFF_BIT];  // [RULE17]

    regs_next.rd_data = read_mux(regs_next, regs_next.ptr);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regs_reg <= REGS_RESET;  // [RULE3] [RULE4]
    end else begin
      regs_reg <= regs_next;
    end
  end

  assign nvm_addr               = regs_reg.nvm_addr;
  assign nvm_wdata              = regs_reg.nvm_data;
  assign nvm_data_wr            = regs_reg.nvm_data_wr;
  assign first_mod_sample       = regs_reg.first_sample;
  assign second_mod_sample      = regs_reg.second_sample;
  assign bsup_en                = regs_reg.bsup_en;
  assign sat_detect_en          = regs_reg.sat_en;
  assign illum_cont_on          = regs_reg.illum_on;
  assign illum_hold_off         = regs_reg.illum_off;
  assign gray_diff_readout      = regs_reg.gray_diff;
  assign gray_illum_on          = regs_reg.gray_on;
  assign gray_illum_off         = regs_reg.gray_off;
  assign bus_address_strap_low  = regs_reg.strap_low;
  assign bus_address_strap_high = regs_reg.strap_high;
endmodule : tcp_ctrl_regs

// ### tcp_pkg.sv
// tcp_pkg: register map, field layout, reset values and state codes of the control page
// assumes: byte-wide registers reached over the two-wire serial port, one system clock
package tcp_pkg;

  // register offsets
  localparam logic [7:0] ADDR_FAMILY_TYPE = 8'h00;
  localparam logic [7:0] ADDR_MASK_REV    = 8'h01;
  localparam logic [7:0] ADDR_NVM_ADDR    = 8'h11;
  localparam logic [7:0] ADDR_NVM_DATA    = 8'h12;
  localparam logic [7:0] ADDR_STRAP       = 8'h20;
  localparam logic [7:0] ADDR_GRAY_MODE   = 8'h3A;
  localparam logic [7:0] ADDR_GRAY_ILLUM  = 8'h3C;

  localparam int FRAMES = 4;
  localparam logic [3:0][7:0] ADDR_FRAME_SEL   = {8'h2B, 8'h28, 8'h25, 8'h22};
  localparam logic [3:0][7:0] ADDR_FRAME_ILLUM = {8'h2D, 8'h2A, 8'h27, 8'h24};

  // reset values
  localparam logic [3:0][7:0] RST_FRAME_SEL   = {8'h3F, 8'h3A, 8'h35, 8'h30};
  localparam logic [7:0]      RST_FRAME_ILLUM = 8'h00;
  localparam logic [7:0]      RST_GRAY_MODE   = 8'h00;
  localparam logic [7:0]      RST_GRAY_ILLUM  = 8'h26;
  localparam logic [7:0]      RST_NVM         = 8'h00;
  localparam logic [7:0]      RST_STRAP       = 8'h00;

  // writable bits; all others hold their reset value
  localparam logic [7:0] MASK_SEL       = 8'h3F;
  localparam logic [7:0] MASK_ILLUM     = 8'h30;
  localparam logic [7:0] MASK_GRAY_MODE = 8'h01;

  // field positions
  localparam int SEL_FIRST_LSB  = 0;
  localparam int SEL_SECOND_LSB = 2;
  localparam int SEL_BSUP_LSB   = 4;
  localparam int ILLUM_ON_BIT   = 4;
  localparam int ILLUM_OFF_BIT  = 5;
  localparam int STRAP_LOW_BIT  = 5;
  localparam int STRAP_HIGH_BIT = 6;
  localparam int GRAY_DIFF_BIT  = 0;

  localparam logic [1:0] BSUP_ON  = 2'b11;
  localparam logic [1:0] BSUP_OFF = 2'b00;

  // clock edges after reset release before the straps are captured
  localparam logic [1:0] STRAP_SETTLE = 2'd3;

  typedef enum logic [5:0] {
    SER_IDLE  = 6'b000001,
    SER_ADDR  = 6'b000010,
    SER_ACK   = 6'b000100,
    SER_WRITE = 6'b001000,
    SER_READ  = 6'b010000,
    SER_RACK  = 6'b100000
  } tcp_ser_state_type;

endpackage : tcp_pkg

// ### tcp_sync.sv
// tcp_sync: two-flop synchroniser, one chain per bit
// assumes: inputs asynchronous to mclk; only the second stage is read outside
`timescale 1ns/1ps
module tcp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output      logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          stage1_reg[b] <= 1'b0;
          stage2_reg[b] <= 1'b0;
        end else begin
          stage1_reg[b] <= async_in[b];
          stage2_reg[b] <= stage1_reg[b];
        end
      end
    end
  endgenerate

  assign sync_out = stage2_reg;
endmodule : tcp_sync

// ### tcp_ser_slave.sv
// tcp_ser_slave: byte engine of the two-wire serial slave port
// assumes: scl/sda are raw pins, sda is open drain, rd_data is ready before scl falls
`timescale 1ns/1ps
module tcp_ser_slave
  import tcp_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [6:0] dev_addr,
  input  wire logic [7:0] rd_data,
  output      logic       sda_o,
  output      logic       sda_oe,
  output      logic       wr_valid,
  output      logic [7:0] wr_data,
  output      logic       wr_first,
  output      logic       rd_next
);
  typedef struct packed {
    tcp_ser_state_type state;
    logic [2:0]        bit_cnt;
    logic [7:0]        shift;
    logic              rw;
    logic              first;
    logic              ack_on;
    logic              scl_d;
    logic              sda_d;
    logic              sda_oe;
    logic              wr_valid;
    logic [7:0]        wr_data;
    logic              wr_first;
    logic              rd_next;
  } tcp_ser_type;

  localparam tcp_ser_type SER_RESET = '{state: SER_IDLE, default: '0};

  tcp_ser_type ser_reg;
  tcp_ser_type ser_next;
  logic        scl_s;
  logic        sda_s;
  logic        scl_rise;
  logic        scl_fall;
  logic [7:0]  byte_in;

  tcp_sync #(.WIDTH(2)) u_pin_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({scl_i, sda_i}),
    .sync_out ({scl_s, sda_s})
  );

  assign scl_rise = scl_s & ~ser_reg.scl_d;
  assign scl_fall = ~scl_s & ser_reg.scl_d;
  assign byte_in  = {ser_reg.shift[6:0], sda_s};

  always_comb begin
    ser_next          = ser_reg;
    ser_next.scl_d    = scl_s;
    ser_next.sda_d    = sda_s;
    ser_next.wr_valid = 1'b0;
    ser_next.rd_next  = 1'b0;
    if (scl_s && ser_reg.scl_d && ser_reg.sda_d && !sda_s) begin
      ser_next.state   = SER_ADDR;
      ser_next.bit_cnt = 3'd0;
      ser_next.sda_oe  = 1'b0;
      ser_next.ack_on  = 1'b0;
    end else if (scl_s && ser_reg.scl_d && !ser_reg.sda_d && sda_s) begin
      ser_next.state  = SER_IDLE;
      ser_next.sda_oe = 1'b0;
    end else begin
      unique case (ser_reg.state)
        SER_IDLE: begin
          ser_next.sda_oe = 1'b0;
        end
        SER_ADDR: begin
          if (scl_rise) begin
            ser_next.shift   = byte_in;
            ser_next.bit_cnt = ser_reg.bit_cnt + 3'd1;
            if (ser_reg.bit_cnt == 3'd7) begin
              if (byte_in[7:1] == dev_addr) begin
                ser_next.state = SER_ACK;
                ser_next.rw    = byte_in[0];
                ser_next.first = 1'b1;
              end else begin
                ser_next.state = SER_IDLE;
              end
            end
          end
        end
        SER_WRITE: begin
          if (scl_rise) begin
            ser_next.shift   = byte_in;
            ser_next.bit_cnt = ser_reg.bit_cnt + 3'd1;
            if (ser_reg.bit_cnt == 3'd7) begin
              // first data byte is the register address [RULE19]
              ser_next.wr_valid = 1'b1;
              ser_next.wr_data  = byte_in;
              ser_next.wr_first = ser_reg.first;
              ser_next.first    = 1'b0;
              ser_next.state    = SER_ACK;
            end
          end
        end
        SER_ACK: begin
          if (scl_fall) begin
            if (!ser_reg.ack_on) begin
              ser_next.ack_on = 1'b1;
              ser_next.sda_oe = 1'b1;
            end else begin
              ser_next.ack_on  = 1'b0;
              ser_next.bit_cnt = 3'd0;
              if (ser_reg.rw) begin
                ser_next.state  = SER_READ;
                ser_next.shift  = rd_data;
                ser_next.sda_oe = ~rd_data[7];
              end else begin
                ser_next.state  = SER_WRITE;
                ser_next.sda_oe = 1'b0;
              end
            end
          end
        end
        SER_READ: begin
          if (scl_rise) begin
            ser_next.bit_cnt = ser_reg.bit_cnt + 3'd1;
            if (ser_reg.bit_cnt == 3'd7) begin
              ser_next.state   = SER_RACK;
              ser_next.rd_next = 1'b1;
            end
          end else if (scl_fall) begin
            ser_next.shift  = {ser_reg.shift[6:0], 1'b0};
            ser_next.sda_oe = ~ser_reg.shift[6];
          end
        end
        SER_RACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              ser_next.state = SER_IDLE;
            end else begin
              ser_next.ack_on = 1'b1;
            end
          end else if (scl_fall) begin
            if (ser_reg.ack_on) begin
              ser_next.ack_on  = 1'b0;
              ser_next.state   = SER_READ;
              ser_next.bit_cnt = 3'd0;
              ser_next.shift   = rd_data;
              ser_next.sda_oe  = ~rd_data[7];
            end else begin
              ser_next.sda_oe = 1'b0;
            end
          end
        end
        default: begin
          ser_next = SER_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ser_reg <= SER_RESET;
    end else begin
      ser_reg <= ser_next;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe   = ser_reg.sda_oe;
  assign wr_valid = ser_reg.wr_valid;
  assign wr_data  = ser_reg.wr_data;
  assign wr_first = ser_reg.wr_first;
  assign rd_next  = ser_reg.rd_next;
endmodule : tcp_ser_slave

// ### tcp_regs_chk.sv
// tcp_regs_chk: port assertions for the control page bank
// assumes: bound onto tcp_ctrl_regs, one clock domain
`timescale 1ns/1ps
module tcp_regs_chk (
  input wire logic            mclk,
  input wire logic            rst_n,
  input wire logic            scl_i,
  input wire logic            sda_o,
  input wire logic            sda_oe,
  input wire logic            frame_start,
  input wire logic [7:0]      nvm_rdata,
  input wire logic            nvm_rdata_valid,
  input wire logic [7:0]      nvm_wdata,
  input wire logic            nvm_data_wr,
  input wire logic [3:0][1:0] first_mod_sample,
  input wire logic [3:0]      bsup_en,
  input wire logic [3:0]      sat_detect_en,
  input wire logic [3:0]      illum_cont_on,
  input wire logic            bus_address_strap_low,
  input wire logic            bus_address_strap_high
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [2:0] cnt_reg;
  // edges since reset release, saturating
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n) cnt_reg <= 3'h0;
    else if (cnt_reg != 3'h7) cnt_reg <= cnt_reg + 3'h1;
  sequence s_scl_high;
    scl_i [*4];
  endsequence
  a_shadow_only:
    assert property ($changed({first_mod_sample, bsup_en, illum_cont_on}) |-> $past(frame_start))
    else $error("frame output moved without frame start");
  a_bsup_sat:
    assert property ((bsup_en & ~sat_detect_en) == 4'h0) else $error("suppression without sat");
  a_strap_once:
    assert property ($changed({bus_address_strap_high, bus_address_strap_low})
      |-> cnt_reg inside {[3'h3:3'h5]}) else $error("strap capture at wrong time");
  a_wr_pulse:
    assert property (nvm_data_wr |=> !nvm_data_wr) else $error("memory write pulse too long");
  a_rdata_load:
    assert property (nvm_rdata_valid |=> nvm_wdata == $past(nvm_rdata))
    else $error("memory data not loaded");
  a_wr_on_high:
    assert property (nvm_data_wr |-> scl_i && !sda_oe) else $error("write taken off clock high");
  a_ack_steady:
    assert property (s_scl_high |-> $stable(sda_oe)) else $error("data moved while clock high");
  a_open_drain:
    assert property (sda_o == 1'b0) else $error("data pin driven high");
endmodule : tcp_regs_chk

bind tcp_ctrl_regs tcp_regs_chk u_chk (
  .mclk, .rst_n, .scl_i, .sda_o, .sda_oe, .frame_start, .nvm_rdata, .nvm_rdata_valid,
  .nvm_wdata, .nvm_data_wr, .first_mod_sample, .bsup_en, .sat_detect_en, .illum_cont_on,
  .bus_address_strap_low, .bus_address_strap_high);

// ### tcp_host_bfm.sv
// tcp_host_bfm: two-wire serial master that configures the control page
// assumes: sda pulled up outside, pins changed at mclk falling edges
`timescale 1ns/1ps
module tcp_host_bfm #(
  parameter logic [6:0] DEV = 7'h12
) (
  input  wire logic mclk,
  output      logic scl,
  output      logic sda_rel,
  input  wire logic sda_line
);
  logic       nack;
  logic [6:0] dev;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
    nack = 1'b0;
    dev = DEV;
  end
  task automatic hp(input int n);
    repeat (n) @(negedge mclk);
  endtask : hp
  task automatic bitx(input logic b, output logic s);
    hp(3);
    sda_rel = b;
    hp(50);
    scl = 1'b1;
    hp(28);
    s = sda_line;
    scl = 1'b0;
  endtask : bitx
  task automatic start();
    hp(3);
    sda_rel = 1'b1;
    hp(50);
    scl = 1'b1;
    hp(28);
    sda_rel = 1'b0;
    hp(28);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    hp(3);
    sda_rel = 1'b0;
    hp(50);
    scl = 1'b1;
    hp(28);
    sda_rel = 1'b1;
    hp(50);
  endtask : stop
  task automatic wbyte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(b[i], s);
    bitx(1'b1, s);
    nack = s;
  endtask : wbyte
  task automatic wr(input logic [7:0] ra, input logic [7:0] d[$]);
    start();
    wbyte({dev, 1'b0});
    wbyte(ra);
    foreach (d[i]) wbyte(d[i]);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] ra, input int n, output logic [7:0] q[$]);
    logic [7:0] b;
    logic       s;
    q = {};
    start();
    wbyte({dev, 1'b0});
    wbyte(ra);
    start();
    wbyte({dev, 1'b1});
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
      bitx(k == n - 1, s);
      q.push_back(b);
    end
    stop();
  endtask : rd
endmodule : tcp_host_bfm

// ### tb.sv
// tb: self-checking bench for the control page register bank
// assumes: tcp_host_bfm as serial master, sda pulled up
`timescale 1ns/1ps
module tb;
  import tcp_pkg::*;
  localparam logic [7:0] FAM = 8'h5C;  // arbitrary value
  localparam logic [7:0] REV = 8'h02;  // arbitrary value
  logic mclk, rst_n, scl_i, sda_rel, sda_o, sda_oe, frame_start, nvm_rdata_valid, nvm_data_wr;
  logic strap_low_i, strap_high_i, gray_diff_readout, gray_illum_on, gray_illum_off;
  logic bus_address_strap_low, bus_address_strap_high;
  logic [7:0] nvm_rdata, nvm_addr, nvm_wdata;
  logic [3:0][1:0] first_mod_sample, second_mod_sample;
  logic [3:0] bsup_en, sat_detect_en, illum_cont_on, illum_hold_off;
  logic [7:0] q[$];
  int n_mismatch, tests_run, n_wr;
  wire logic sda_i = sda_rel & ~(sda_oe & ~sda_o);
  // memory write strobes, counted away from the launching edge
  always @(negedge mclk) n_wr += int'(nvm_data_wr);
  tcp_ctrl_regs #(.FAMILY_TYPE_ID(FAM), .MASK_REVISION_ID(REV), .DEV_ADDR_UPPER(5'h04)) u_dut (
    .mclk, .rst_n, .scl_i, .sda_i, .sda_o, .sda_oe, .strap_low_i, .strap_high_i, .frame_start,
    .nvm_rdata, .nvm_rdata_valid, .nvm_addr, .nvm_wdata, .nvm_data_wr, .first_mod_sample,
    .second_mod_sample, .bsup_en, .sat_detect_en, .illum_cont_on, .illum_hold_off,
    .gray_diff_readout, .gray_illum_on, .gray_illum_off, .bus_address_strap_low,
    .bus_address_strap_high);
  tcp_host_bfm #(.DEV(7'h12)) u_host (.mclk, .scl(scl_i), .sda_rel, .sda_line(sda_i));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] ra, input logic [7:0] e[$]);
    u_host.rd(ra, e.size(), q);
    foreach (e[i]) chk($sformatf("reg %h", ra + 8'(i)), q[i], e[i]);
  endtask : rdc
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
  endtask : do_reset
  task automatic finish_test();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  initial begin
    #900000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    {frame_start, nvm_rdata_valid, nvm_rdata, strap_low_i, strap_high_i} = 12'h001;
    n_mismatch = 0;
    tests_run = 0;
    do_reset();
    chk("samples", {first_mod_sample, second_mod_sample}, 16'hE4E4);
    chk("bsup", {bsup_en, sat_detect_en}, 8'hFF);
    chk("gray", {gray_diff_readout, gray_illum_on, gray_illum_off}, 3'b001);
    chk("nvm", {nvm_addr, nvm_wdata}, 16'h0000);
    chk("straps", {bus_address_strap_high, bus_address_strap_low}, 2'b10);
    rdc(8'h00, {FAM, REV});
    rdc(8'h20, {8'h40, 0, 8'h30, 0, 0, 8'h35, 0, 0, 8'h3A, 0, 0, 8'h3F, 0, 0});
    rdc(8'h3A, {8'h00, 0, 8'h26});
    for (int f = 0; f < FRAMES; f++)
      u_host.wr(ADDR_FRAME_SEL[f], {8'((3 - f) * 8'h15) | 8'hC0});
    u_host.wr(8'h24, {8'hFF});
    rdc(8'h22, {8'h3F, 0, 8'h30, 8'h2A});
    chk("pending", {first_mod_sample, bsup_en}, 12'hE4F);
    frame_start = 1'b1;
    @(negedge mclk);
    frame_start = 1'b0;
    @(negedge mclk);
    chk("samples", {first_mod_sample, second_mod_sample}, 16'h1B1B);
    chk("bsup", {bsup_en, sat_detect_en}, 8'h17);
    chk("illum", {illum_cont_on, illum_hold_off}, 8'h11);
    u_host.wr(8'h3A, {8'hFF});
    u_host.wr(8'h3C, {8'h10});
    chk("gray", {gray_diff_readout, gray_illum_on, gray_illum_off}, 3'b110);
    rdc(8'h3A, {8'h01, 0, 8'h16});
    u_host.wr(8'h00, {8'h00, 8'h00});
    rdc(8'h00, {FAM, REV});
    u_host.wr(8'h11, {8'h7E, 8'hC3});
    chk("nvm", {nvm_addr, nvm_wdata}, 16'h7EC3);
    chk("nvm strobes", 16'(n_wr), 16'h0001);
    nvm_rdata = 8'h99;
    nvm_rdata_valid = 1'b1;
    @(negedge mclk);
    nvm_rdata_valid = 1'b0;
    rdc(8'h12, {8'h99});
    u_host.dev = 7'h13;
    rdc(8'h00, {8'hFF});
    chk("nack", u_host.nack, 1'b1);
    strap_low_i = 1'b1;
    do_reset();
    chk("straps", {bus_address_strap_high, bus_address_strap_low}, 2'b11);
    rdc(8'h22, {8'h30, 0, 8'h00});
    chk("live", {first_mod_sample, bsup_en, gray_illum_off}, 13'h1C9F);
    finish_test();
  end
endmodule : tb
